// ===== pkg/pll_ctrl_pkg.sv
// Register map, field layout and state types of the PLL multiplier control
package pll_ctrl_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CTRL1  = 8'h00;
  localparam logic [7:0] IDX_CTRL3  = 8'h02;
  localparam logic [7:0] IDX_CTRL4  = 8'h03;
  localparam logic [7:0] IDX_STATUS = 8'h1b;
  // First control register fields
  localparam int VCO_CAL_BIT = 24;
  // Third control register fields
  localparam int DIV_LSB     = 8;
  localparam int DIV_MSB     = 15;
  localparam int MANUAL_BIT  = 6;
  localparam int CODE_LSB    = 3;
  localparam int CODE_MSB    = 5;
  localparam int PLL_EN_BIT  = 18;
  // Fourth control register fields
  localparam int DAC_CAL_BIT = 24;
  // Status register fields
  localparam int LOCK_BIT    = 24;
  localparam int BUSY_BIT    = 25;
  localparam int CALDONE_BIT = 26;
  // Reset values and limits
  localparam logic [7:0] DIV_RST  = 8'h0a;
  localparam logic [7:0] DIV_MIN  = 8'h0a;
  localparam logic [2:0] CODE_RST = 3'h3;
  // Calibration sequencer
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_HOLD} cal_state_type;
endpackage

// ===== design/pll_clock_multiplier_control.sv
// APB controlled PLL multiplier control: divider, pump current, calibration, lock
//
// Behaviour
// RULE1: Multiplication factors are even only, from 20 to 510 times reference.
// RULE2: Divider count is 8 bits at bits 15:8 of index 0x02, legal 10..255.
// RULE3: Software must never program a divider count below ten.
// RULE4: Overall multiplication always equals twice the divider count.
// RULE5: Pump current comes from VCO calibration unless manual bit 6 is set.
// RULE6: Manual code bits 5:3 select 125..1000 uA in 125 uA steps, default 011.
// RULE7: Software sets VCO calibration bit 24 of index 0x00 once reference is stable.
// RULE8: A new VCO calibration starts only after the bit was cleared first.
// RULE9: VCO calibration completes before DAC clock calibration is triggered; code only blocks a DAC start while a VCO calibration runs with PLL enabled.
// RULE10: Lock bit 24 of index 0x1b is high once the PLL has locked.
// RULE11: Software picks the divider so the system clock is 2.4 to 2.5 GHz.
// RULE12: A manual current should rise with the divider count.
// RULE13: PLL enable picks PLL output, else the reference passes straight through.
// RULE14: Software sets then clears DAC calibration bit 24 of index 0x03.
// RULE15: Lock reads low while bypassed or while a VCO calibration runs.
`timescale 1ns/1ns
module pll_clock_multiplier_control
  import pll_ctrl_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        pllLocked,
  input  wire logic        vcoCalDone,
  input  wire logic [2:0]  autoPumpCode,
  output logic [7:0]       feedbackDivider,
  output logic [8:0]       multFactor,
  output logic [2:0]       pumpCurrentCode,
  output logic             pllEnable,
  output logic             vcoCalStart,
  output logic             dacCalStart
);

  // The divider field is fixed at eight bits
  if (DIV_W != 8) begin : g_chk
    $error("DIV_W must be 8");
  end

  logic [DIV_W-1:0] divider_ff, nxt_divider;
  logic             manual_ff, nxt_manual;
  logic [2:0]       code_ff, nxt_code;
  logic [2:0]       auto_ff, nxt_auto;
  logic             pllEn_ff, nxt_pllEn;
  logic             vcoBit_ff, nxt_vcoBit;
  logic             dacBit_ff, nxt_dacBit;
  logic             calDone_ff, nxt_calDone;
  logic             vcoStart_ff, nxt_vcoStart;
  logic             dacStart_ff, nxt_dacStart;
  logic [31:0]      rdata_ff, nxt_rdata;
  cal_state_type    cal_ff, nxt_cal;
  logic [7:0]       idx;
  logic             hit;
  logic             wrEn;
  logic             lockView;

  // Decode; only word-aligned addresses of the four defined indexes are mapped
  always_comb begin
    idx = paddr[9:2];
    hit = 1'b0;
    if (paddr[31:10] != 22'h0 || paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (idx == IDX_CTRL1) begin
      hit = 1'b1;
    end else if (idx == IDX_CTRL3) begin
      hit = 1'b1;
    end else if (idx == IDX_CTRL4) begin
      hit = 1'b1;
    end else if (idx == IDX_STATUS) begin
      hit = 1'b1;
    end
  end

  // Zero wait states; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wrEn    = psel & penable & pwrite & hit;

  // Lock is hidden while bypassed or while the VCO is being tuned
  assign lockView = pllEn_ff & pllLocked & (cal_ff != CAL_RUN); // RULE10 RULE15

  // Register writes
  always_comb begin
    nxt_divider = divider_ff;
    nxt_manual  = manual_ff;
    nxt_code    = code_ff;
    nxt_pllEn   = pllEn_ff;
    nxt_vcoBit  = vcoBit_ff;
    nxt_dacBit  = dacBit_ff;
    if (wrEn && idx == IDX_CTRL1) begin
      nxt_vcoBit = pwdata[VCO_CAL_BIT]; // RULE7
    end else if (wrEn && idx == IDX_CTRL3) begin
      // Counts below the minimum would overrun the VCO; they are dropped
      if (pwdata[DIV_MSB:DIV_LSB] >= DIV_MIN) begin // RULE2 RULE3
        nxt_divider = pwdata[DIV_MSB:DIV_LSB];
      end
      nxt_manual = pwdata[MANUAL_BIT]; // RULE5
      nxt_code   = pwdata[CODE_MSB:CODE_LSB]; // RULE6
      nxt_pllEn  = pwdata[PLL_EN_BIT]; // RULE13
    end else if (wrEn && idx == IDX_CTRL4) begin
      nxt_dacBit = pwdata[DAC_CAL_BIT]; // RULE14
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      divider_ff <= DIV_RST;
      manual_ff  <= 1'b0;
      code_ff    <= CODE_RST; // RULE6
      pllEn_ff   <= 1'b0;
      vcoBit_ff  <= 1'b0;
      dacBit_ff  <= 1'b0;
    end else begin
      divider_ff <= nxt_divider;
      manual_ff  <= nxt_manual;
      code_ff    <= nxt_code;
      pllEn_ff   <= nxt_pllEn;
      vcoBit_ff  <= nxt_vcoBit;
      dacBit_ff  <= nxt_dacBit;
    end
  end

  // VCO calibration sequencer; a held bit never retriggers
  always_comb begin
    nxt_cal      = cal_ff;
    nxt_auto     = auto_ff;
    nxt_calDone  = calDone_ff;
    nxt_vcoStart = 1'b0;
    nxt_dacStart = 1'b0;
    case (cal_ff)
      CAL_IDLE: begin
        if (vcoBit_ff && pllEn_ff) begin // RULE8
          nxt_cal      = CAL_RUN;
          nxt_vcoStart = 1'b1;
          nxt_calDone  = 1'b0;
        end
      end
      CAL_RUN: begin
        if (vcoCalDone) begin
          nxt_auto    = autoPumpCode; // RULE5
          nxt_calDone = 1'b1;
          nxt_cal     = CAL_HOLD;
        end
      end
      default: begin
        if (!vcoBit_ff) begin // RULE8
          nxt_cal = CAL_IDLE;
        end
      end
    endcase
    // A DAC calibration request raised while the VCO is still being tuned with the PLL enabled is dropped, not held
    if (nxt_dacBit && !dacBit_ff && !(pllEn_ff && cal_ff == CAL_RUN)) begin // RULE9
      nxt_dacStart = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cal_ff      <= CAL_IDLE;
      auto_ff     <= CODE_RST;
      calDone_ff  <= 1'b0;
      vcoStart_ff <= 1'b0;
      dacStart_ff <= 1'b0;
    end else begin
      cal_ff      <= nxt_cal;
      auto_ff     <= nxt_auto;
      calDone_ff  <= nxt_calDone;
      vcoStart_ff <= nxt_vcoStart;
      dacStart_ff <= nxt_dacStart;
    end
  end

  // Read data
  always_comb begin
    nxt_rdata = rdata_ff;
    if (psel && !penable && !pwrite) begin
      nxt_rdata = 32'h0;
      if (idx == IDX_CTRL1) begin
        nxt_rdata[VCO_CAL_BIT] = vcoBit_ff;
      end else if (idx == IDX_CTRL3) begin
        nxt_rdata[DIV_MSB:DIV_LSB]   = divider_ff;
        nxt_rdata[MANUAL_BIT]        = manual_ff;
        nxt_rdata[CODE_MSB:CODE_LSB] = code_ff;
        nxt_rdata[PLL_EN_BIT]        = pllEn_ff;
      end else if (idx == IDX_CTRL4) begin
        nxt_rdata[DAC_CAL_BIT] = dacBit_ff;
      end else if (idx == IDX_STATUS) begin
        nxt_rdata[LOCK_BIT]    = lockView; // RULE10
        nxt_rdata[BUSY_BIT]    = (cal_ff == CAL_RUN);
        nxt_rdata[CALDONE_BIT] = calDone_ff;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Read data and analog-facing outputs
  assign prdata          = rdata_ff;
  assign feedbackDivider = divider_ff;
  assign multFactor      = {1'b0, divider_ff} << 1; // RULE1 RULE4
  assign pumpCurrentCode = manual_ff ? code_ff : auto_ff; // RULE5 RULE6
  assign pllEnable       = pllEn_ff; // RULE13
  assign vcoCalStart     = vcoStart_ff;
  assign dacCalStart     = dacStart_ff;

  property p_even_mult;
    @(posedge ref_clk) disable iff (rst)
      multFactor[0] == 1'b0 && multFactor >= 9'd20 && multFactor <= 9'd510;
  endproperty
  a_even_mult: assert property (p_even_mult) else $error("mult factor out of range"); // RULE1

  property p_two_n;
    @(posedge ref_clk) disable iff (rst) multFactor == {feedbackDivider, 1'b0};
  endproperty
  a_two_n: assert property (p_two_n) else $error("mult is not twice divider"); // RULE4

  property p_low_div_dropped;
    @(posedge ref_clk) disable iff (rst)
      wrEn && idx == IDX_CTRL3 && pwdata[DIV_MSB:DIV_LSB] < DIV_MIN
      |=> $stable(feedbackDivider);
  endproperty
  a_low_div_dropped: assert property (p_low_div_dropped) else $error("low divider taken"); // RULE2

  property p_pump_sel;
    @(posedge ref_clk) disable iff (rst)
      wrEn && idx == IDX_CTRL3 && pwdata[MANUAL_BIT]
      |=> pumpCurrentCode == $past(pwdata[CODE_MSB:CODE_LSB]);
  endproperty
  a_pump_sel: assert property (p_pump_sel) else $error("manual code not used"); // RULE5

  // Remembers a start until the bit is seen low; software may drop the bit at any time
  logic heldSinceStart_ff;
  logic nxt_heldSinceStart;

  always_comb begin
    nxt_heldSinceStart = vcoCalStart | (heldSinceStart_ff & vcoBit_ff);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      heldSinceStart_ff <= 1'b0;
    end else begin
      heldSinceStart_ff <= nxt_heldSinceStart;
    end
  end

  property p_no_retrigger;
    @(posedge ref_clk) disable iff (rst)
      heldSinceStart_ff |-> !vcoCalStart;
  endproperty
  a_no_retrigger: assert property (p_no_retrigger) else $error("cal retriggered"); // RULE8

  property p_lock_view;
    @(posedge ref_clk) disable iff (rst)
      psel && !penable && !pwrite && idx == IDX_STATUS
      |=> prdata[LOCK_BIT] == $past(pllEn_ff & pllLocked & (cal_ff != CAL_RUN));
  endproperty
  a_lock_view: assert property (p_lock_view) else $error("lock bit wrong"); // RULE10

  property p_lock_low_cal;
    @(posedge ref_clk) disable iff (rst)
      vcoCalStart |-> !lockView;
  endproperty
  a_lock_low_cal: assert property (p_lock_low_cal) else $error("lock high in cal"); // RULE15

  property p_dac_after_vco;
    @(posedge ref_clk) disable iff (rst)
      dacCalStart |-> !($past(cal_ff) == CAL_RUN && $past(pllEn_ff));
  endproperty
  a_dac_after_vco: assert property (p_dac_after_vco) else $error("dac cal during vco"); // RULE9

  property p_bypass;
    @(posedge ref_clk) disable iff (rst)
      wrEn && idx == IDX_CTRL3 |=> pllEnable == $past(pwdata[PLL_EN_BIT]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("pll enable not taken"); // RULE13

endmodule // pll_clock_multiplier_control

// ===== tb/pll_analog_model.sv
// Behavioural model of the analog PLL and its VCO calibration engine
`timescale 1ns/1ns
module pll_analog_model #(
  parameter int         DLY  = 20,
  parameter logic [2:0] CODE = 3'h5
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       pllEnable,
  input  wire logic       vcoCalStart,
  output logic            pllLocked,
  output logic            vcoCalDone,
  output logic [2:0]      autoPumpCode
);
  int   calCnt_ff;
  logic lock_ff;
  // Lock stays up during calibration, so the device itself must mask it
  always_ff @(posedge ref_clk) begin
    lock_ff <= pllEnable & ~rst;
    if (rst || vcoCalStart) begin
      calCnt_ff <= rst ? 0 : DLY;
    end else if (calCnt_ff > 0) begin
      calCnt_ff <= calCnt_ff - 1;
    end
  end
  // Code is valid only with the done pulse; otherwise inverted to expose late sampling
  assign pllLocked    = lock_ff;
  assign vcoCalDone   = (calCnt_ff == 1);
  assign autoPumpCode = vcoCalDone ? CODE : ~CODE;
endmodule // pll_analog_model

// ===== tb/pll_clock_multiplier_control_tb_top.sv
// Self-checking bench for the PLL multiplier control block
`timescale 1ns/1ns
module pll_clock_multiplier_control_tb_top;
  import pll_ctrl_pkg::*;
  logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic        pready, pslverr, errSeen, pllLocked, vcoCalDone;
  logic        pllEnable, vcoCalStart, dacCalStart;
  logic [2:0]  autoPumpCode, pumpCurrentCode;
  logic [7:0]  feedbackDivider;
  logic [8:0]  multFactor;
  logic [15:0] lfsrState = 16'h0041;
  int error_cnt = 0, compares = 0, vcoCnt = 0, dacCnt = 0, dv;
  int expDiv = 10, expMan = 0, expCode = 3, expAuto = 3, expEn = 0;

  pll_clock_multiplier_control u_pll_clock_multiplier_control (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pllLocked(pllLocked), .vcoCalDone(vcoCalDone), .autoPumpCode(autoPumpCode),
    .feedbackDivider(feedbackDivider), .multFactor(multFactor),
    .pumpCurrentCode(pumpCurrentCode), .pllEnable(pllEnable),
    .vcoCalStart(vcoCalStart), .dacCalStart(dacCalStart));
  pll_analog_model u_pll_analog_model (
    .ref_clk(ref_clk), .rst(rst), .pllEnable(pllEnable), .vcoCalStart(vcoCalStart),
    .pllLocked(pllLocked), .vcoCalDone(vcoCalDone), .autoPumpCode(autoPumpCode));

  initial forever #2 ref_clk = ~ref_clk;
  // Pulses are one cycle wide, so count them rather than poll
  always @(posedge ref_clk) begin
    vcoCnt += vcoCalStart;
    dacCnt += dacCalStart;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic checkOuts();
    @(negedge ref_clk);
    chk("divider", 32'(feedbackDivider), 32'(expDiv));
    chk("mult", 32'(multFactor), 32'(2 * expDiv));
    chk("pump", 32'(pumpCurrentCode), 32'(expMan ? expCode : expAuto));
    chk("enable", 32'(pllEnable), 32'(expEn));
  endtask
  task automatic setCtrl3(input int en, input int d, input int man, input int code);
    apb(1, 32'h8, 32'((en << 18) | (d << 8) | (man << 6) | (code << 3)));
    if (d >= 10) expDiv = d;
    expEn = en;
    expMan = man;
    expCode = code;
    checkOuts();
    apb(0, 32'h8, 0);
    chk("ctrl3", rd & 32'h0000ff78, 32'((expDiv << 8) | (man << 6) | (code << 3)));
  endtask
  task automatic vcoTrig(input logic [31:0] v, input int expCnt);
    apb(1, 32'h0, v << VCO_CAL_BIT);
    repeat (30) @(posedge ref_clk);
    chk("vco starts", 32'(vcoCnt), 32'(expCnt));
  endtask
  task automatic readLock(input logic exp);
    apb(0, 32'h6c, 0);
    chk("lock", 32'(rd[LOCK_BIT]), 32'(exp));
  endtask
  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    checkOuts();
    // Boundary dividers first, then random ones; every manual code is visited
    for (int i = 0; i < 12; i++) begin
      lfsrState = lfsr(lfsrState);
      dv = (i == 0) ? 9 : (i == 1) ? 255 : (i == 2) ? 10 : int'(lfsrState[7:0]);
      setCtrl3(0, dv, int'(lfsrState[8]), i % 8);
    end
    apb(1, 32'h10, 32'hffffffff);
    chk("slverr", 32'(errSeen), 1);
    apb(0, 32'h10, 0);
    chk("unmapped read", rd, 0);
    checkOuts();
    // Divider 40 with a 30 MHz reference lands at 2.4 GHz
    setCtrl3(1, 40, 0, 3);
    apb(1, 32'h0, 32'h1 << VCO_CAL_BIT);
    readLock(0);
    chk("busy", 32'(rd[BUSY_BIT]), 1);
    repeat (30) @(posedge ref_clk);
    chk("vco starts", 32'(vcoCnt), 1);
    expAuto = 5;
    checkOuts();
    readLock(1);
    chk("cal done", 32'(rd[CALDONE_BIT]), 1);
    vcoTrig(1, 1);
    vcoTrig(0, 1);
    vcoTrig(1, 2);
    apb(1, 32'hc, 32'h1 << DAC_CAL_BIT);
    repeat (3) @(posedge ref_clk);
    chk("dac starts", 32'(dacCnt), 1);
    apb(1, 32'hc, 0);
    // A DAC request raised while the VCO is still tuning is refused
    apb(1, 32'h0, 0);
    apb(1, 32'h0, 32'h1 << VCO_CAL_BIT);
    apb(1, 32'hc, 32'h1 << DAC_CAL_BIT);
    repeat (30) @(posedge ref_clk);
    chk("dac in vco cal", 32'(dacCnt), 1);
    chk("vco starts", 32'(vcoCnt), 3);
    apb(1, 32'hc, 0);
    // Code 011 is the recommended current for a divider of 40
    setCtrl3(0, 40, 1, 3);
    readLock(0);
    report_and_stop();
  end
endmodule // pll_clock_multiplier_control_tb_top
